// *** logic/lane_cond_pkg.sv ***
// constants for the lane conditioning register slice
// assumes a 200 MHz register clock and an 8-bit register port
package lane_cond_pkg;

  // register offsets
  localparam logic [7:0] OFS_DETECT_CTRL = 8'h2b;
  localparam logic [7:0] OFS_EQUALIZER = 8'h2c;
  localparam logic [7:0] OFS_SWING_CTRL = 8'h2d;
  localparam logic [7:0] OFS_DEEMPH_CTRL = 8'h2e;
  localparam logic [7:0] OFS_LANE_SPARE = 8'h2f;
  localparam logic [7:0] OFS_SPARE_A = 8'h30;
  localparam logic [7:0] OFS_SPARE_B = 8'h31;
  localparam logic [7:0] OFS_SPARE_C = 8'h32;
  localparam logic [7:0] OFS_SLOT_B0_SPARE = 8'h33;

  // reset values
  localparam logic [7:0] RST_DETECT_CTRL = 8'h00;
  localparam logic [7:0] RST_EQUALIZER = 8'h2f;
  localparam logic [7:0] RST_SWING_CTRL = 8'had;
  localparam logic [7:0] RST_DEEMPH_CTRL = 8'h02;
  localparam logic [7:0] RST_LANE_SPARE = 8'h00;
  localparam logic [7:0] RST_SPARE_A = 8'h00;
  localparam logic [7:0] RST_SPARE_B = 8'h00;
  localparam logic [7:0] RST_SPARE_C = 8'h00;
  localparam logic [7:0] RST_SLOT_B0_SPARE = 8'h2f;

  // field positions
  localparam int DETECT_MODE_LSB = 2;
  localparam int SC_PROT_BIT = 7;
  localparam int PROTO_CLASS_BIT = 6;
  localparam int SWING_LSB = 0;
  localparam int DETECT_STATUS_BIT = 7;
  localparam int DEEMPH_LSB = 0;

  // receiver detect codes
  typedef enum logic [1:0]
  {
    DETECT_HIZ = 2'b00,
    DETECT_AUTO_LIMITED = 2'b01,
    DETECT_AUTO_FOREVER = 2'b10,
    DETECT_FIXED_50 = 2'b11
  } detect_mode_t;

  // timing
  localparam int unsigned CLOCK_HZ = 200_000_000;
  localparam int unsigned DETECT_INTERVAL_MS = 12;
  localparam int unsigned DETECT_WINDOW_MS = 600;
  localparam int unsigned DETECT_INTERVAL_CYCLES =
    DETECT_INTERVAL_MS * (CLOCK_HZ / 1000);
  localparam int unsigned DETECT_MAX_ATTEMPTS =
    DETECT_WINDOW_MS / DETECT_INTERVAL_MS;

endpackage : lane_cond_pkg

// *** logic/lane_conditioning_ctrl_regs.sv ***
// register slice 0x2b..0x33 for one lane input and one unused output slot
// assumes a byte-wide register port driven by the management serial
// controller or configuration loader on the same clock
`timescale 1ns/100ps

// Summary of operation
// [RULE1] detect code 00 leaves the lane input high impedance, unterminated
// [RULE2] code 01 probes far end every 12 ms, gives up after 50 tries
// [RULE3] code 10 probes every 12 ms until a receiver is found
// [RULE4] auto codes keep input high impedance until found, then 50 ohm
// [RULE5] code 11 applies 50 ohm termination with no detection
// [RULE6] detect field rules only when global override set, else the pin
// [RULE7] eight-bit equalizer level, 256 steps, resets to 0x2f
// [RULE8] swing register bit 7 enables output short-circuit protection
// [RULE9] swing bit 6 picks protocol class, only under mode override
// [RULE10] host writes 101 into swing bits 5 to 3
// [RULE11] three-bit swing code, 0.6 V to 1.3 V, default 101
// [RULE12] deemphasis bit 7 reads back termination state, read only
// [RULE13] three-bit deemphasis code, 0 to -12 dB, default 010
// [RULE14] reset loads defaults; writes act on the lane at once; protocol class and detect code take effect one clock later
module lane_conditioning_ctrl_regs
  import lane_cond_pkg::*;
#(
  parameter int unsigned DETECT_INTERVAL = DETECT_INTERVAL_CYCLES
)
(
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_RD,
  output logic [7:0] O_RD_DATA,
  output logic O_RD_HIT,
  input wire logic I_DETECT_OVERRIDE,
  input wire logic [1:0] I_DETECT_PIN,
  input wire logic I_MODE_OVERRIDE,
  input wire logic I_MODE_PIN,
  input wire logic I_FAR_END_PRESENT,
  output logic O_DETECT_ATTEMPT,
  output logic O_LANE_ZERO_INPUT_TERM,
  output logic [7:0] O_EQUALIZER_SETTING,
  output logic O_SHORT_PROT_EN,
  output logic O_PROTO_GEN12,
  output logic [2:0] O_OUTPUT_SWING,
  output logic [2:0] O_DEEMPHASIS_LEVEL
);

  logic [7:0] detect_ctrl_r;
  logic [7:0] equalizer_r;
  logic [7:0] swing_ctrl_r;
  logic [6:0] deemph_ctrl_r;
  logic [7:0] lane_spare_r;
  logic [7:0] spare_a_r;
  logic [7:0] spare_b_r;
  logic [7:0] spare_c_r;
  logic [7:0] slot_b0_spare_r;
  logic [7:0] rd_data_r;
  logic rd_hit_r;
  logic [1:0] det_pin_meta_r;
  logic [1:0] det_pin_r;
  logic mode_pin_meta_r;
  logic mode_pin_r;
  logic far_meta_r;
  logic far_r;
  logic proto_r;
  wire [1:0] detect_mode;
  wire term_50;
  wire hit;
  wire [7:0] rd_mux;
  wire wr_detect;
  wire wr_eq;
  wire wr_swing;
  wire wr_deemph;
  wire wr_spare;
  wire wr_spare_a;
  wire wr_spare_b;
  wire wr_spare_c;
  wire wr_slot_b0;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      det_pin_meta_r <= 2'b00;
      det_pin_r <= 2'b00;
      mode_pin_meta_r <= 1'b0;
      mode_pin_r <= 1'b0;
      far_meta_r <= 1'b0;
      far_r <= 1'b0;
    end
    else
    begin
      det_pin_meta_r <= I_DETECT_PIN;
      det_pin_r <= det_pin_meta_r;
      mode_pin_meta_r <= I_MODE_PIN;
      mode_pin_r <= mode_pin_meta_r;
      far_meta_r <= I_FAR_END_PRESENT;
      far_r <= far_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write decode
  assign wr_detect = I_REG_WR && (I_REG_ADDR == OFS_DETECT_CTRL);
  assign wr_eq = I_REG_WR && (I_REG_ADDR == OFS_EQUALIZER);
  assign wr_swing = I_REG_WR && (I_REG_ADDR == OFS_SWING_CTRL);
  assign wr_deemph = I_REG_WR && (I_REG_ADDR == OFS_DEEMPH_CTRL);
  assign wr_spare = I_REG_WR && (I_REG_ADDR == OFS_LANE_SPARE);
  assign wr_spare_a = I_REG_WR && (I_REG_ADDR == OFS_SPARE_A);
  assign wr_spare_b = I_REG_WR && (I_REG_ADDR == OFS_SPARE_B);
  assign wr_spare_c = I_REG_WR && (I_REG_ADDR == OFS_SPARE_C);
  assign wr_slot_b0 = I_REG_WR && (I_REG_ADDR == OFS_SLOT_B0_SPARE);

  //////////////////////////////////////////////////////////////////////////
  // register storage, defaults on reset
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      detect_ctrl_r <= RST_DETECT_CTRL; // [RULE14]
      equalizer_r <= RST_EQUALIZER; // [RULE7]
      swing_ctrl_r <= RST_SWING_CTRL; // [RULE11]
      deemph_ctrl_r <= RST_DEEMPH_CTRL[6:0]; // [RULE13]
      lane_spare_r <= RST_LANE_SPARE;
      spare_a_r <= RST_SPARE_A;
      spare_b_r <= RST_SPARE_B;
      spare_c_r <= RST_SPARE_C;
      slot_b0_spare_r <= RST_SLOT_B0_SPARE;
    end
    else
    begin
      if (wr_detect)
        detect_ctrl_r <= I_REG_WDATA;
      if (wr_eq)
        equalizer_r <= I_REG_WDATA; // [RULE7]
      if (wr_swing)
        swing_ctrl_r <= I_REG_WDATA; // [RULE10]
      if (wr_deemph)
        deemph_ctrl_r <= I_REG_WDATA[6:0]; // [RULE12]
      if (wr_spare)
        lane_spare_r <= I_REG_WDATA;
      if (wr_spare_a)
        spare_a_r <= I_REG_WDATA;
      if (wr_spare_b)
        spare_b_r <= I_REG_WDATA;
      if (wr_spare_c)
        spare_c_r <= I_REG_WDATA;
      if (wr_slot_b0)
        slot_b0_spare_r <= I_REG_WDATA;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // effective detect code: register under override, else the pin
  assign detect_mode = I_DETECT_OVERRIDE ?
    detect_ctrl_r[DETECT_MODE_LSB +: 2] : det_pin_r; // [RULE6]

  rx_detect_seq #(
    .INTERVAL_CYCLES(DETECT_INTERVAL)
  ) u_detect (
    .i_clock(I_CLOCK),
    .i_sys_rst(I_SYS_RST),
    .i_mode(detect_mode),
    .i_far_end_present(far_r),
    .o_attempt(O_DETECT_ATTEMPT),
    .o_term_50(term_50)
  );

  //////////////////////////////////////////////////////////////////////////
  // read mux; status bit 7 of deemphasis shows termination
  assign hit = (I_REG_ADDR >= OFS_DETECT_CTRL) &&
               (I_REG_ADDR <= OFS_SLOT_B0_SPARE);
  assign rd_mux =
    (I_REG_ADDR == OFS_DETECT_CTRL) ? detect_ctrl_r :
    (I_REG_ADDR == OFS_EQUALIZER) ? equalizer_r :
    (I_REG_ADDR == OFS_SWING_CTRL) ? swing_ctrl_r :
    (I_REG_ADDR == OFS_DEEMPH_CTRL) ? {term_50, deemph_ctrl_r} : // [RULE12]
    (I_REG_ADDR == OFS_LANE_SPARE) ? lane_spare_r :
    (I_REG_ADDR == OFS_SPARE_A) ? spare_a_r :
    (I_REG_ADDR == OFS_SPARE_B) ? spare_b_r :
    (I_REG_ADDR == OFS_SPARE_C) ? spare_c_r :
    (I_REG_ADDR == OFS_SLOT_B0_SPARE) ? slot_b0_spare_r :
    8'h00;

  //////////////////////////////////////////////////////////////////////////
  // read data capture and effective protocol class
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      rd_data_r <= 8'h00;
      rd_hit_r <= 1'b0;
      proto_r <= 1'b0;
    end
    else
    begin
      if (I_REG_RD)
      begin
        rd_data_r <= rd_mux;
        rd_hit_r <= hit;
      end
      proto_r <= I_MODE_OVERRIDE ?
        swing_ctrl_r[PROTO_CLASS_BIT] : mode_pin_r; // [RULE9]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // lane controls from the registers; termination from the detect sequencer, protocol class from proto_r
  assign O_RD_DATA = rd_data_r;
  assign O_RD_HIT = rd_hit_r;
  assign O_LANE_ZERO_INPUT_TERM = term_50; // [RULE1] [RULE4]
  assign O_EQUALIZER_SETTING = equalizer_r; // [RULE14]
  assign O_SHORT_PROT_EN = swing_ctrl_r[SC_PROT_BIT]; // [RULE8]
  assign O_PROTO_GEN12 = proto_r;
  assign O_OUTPUT_SWING = swing_ctrl_r[SWING_LSB +: 3]; // [RULE11]
  assign O_DEEMPHASIS_LEVEL = deemph_ctrl_r[DEEMPH_LSB +: 3]; // [RULE13]

endmodule : lane_conditioning_ctrl_regs

// *** logic/rx_detect_seq.sv ***
// far-end receiver detect sequencer for one lane input
// assumes the probe result is already synchronised to i_clock
`timescale 1ns/100ps
module rx_detect_seq
  import lane_cond_pkg::*;
#(
  parameter int unsigned INTERVAL_CYCLES = DETECT_INTERVAL_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_mode,
  input wire logic i_far_end_present,
  output logic o_attempt,
  output logic o_term_50
);

  typedef enum logic [1:0]
  {
    DET_HIZ = 2'b00,
    DET_SEARCH = 2'b01,
    DET_FOUND = 2'b10,
    DET_STOPPED = 2'b11
  } detect_state_t;

  detect_state_t state_r;
  logic [1:0] mode_last_r;
  logic [23:0] tick_cnt_r;
  logic [5:0] attempts_r;
  logic attempt_r;
  wire restart;
  wire is_auto;
  wire tick;
  wire last_attempt;

  //////////////////////////////////////////////////////////////////////////
  // decode
  assign restart = (i_mode != mode_last_r);
  assign is_auto = (i_mode == DETECT_AUTO_LIMITED) ||
                   (i_mode == DETECT_AUTO_FOREVER);
  assign tick = (tick_cnt_r == 24'(INTERVAL_CYCLES - 1));
  assign last_attempt = (i_mode == DETECT_AUTO_LIMITED) &&
                        (attempts_r == 6'(DETECT_MAX_ATTEMPTS - 1)); // [RULE2]

  //////////////////////////////////////////////////////////////////////////
  // detect state, interval timer and attempt count
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      state_r <= DET_HIZ;
      mode_last_r <= 2'b00;
      tick_cnt_r <= 24'h000000;
      attempts_r <= 6'h00;
      attempt_r <= 1'b0;
    end
    else
    begin
      mode_last_r <= i_mode;
      attempt_r <= 1'b0;
      if (restart)
      begin
        state_r <= is_auto ? DET_SEARCH : DET_HIZ; // [RULE1] [RULE5]
        tick_cnt_r <= 24'h000000;
        attempts_r <= 6'h00;
      end
      else
      begin
        unique case (state_r)
          DET_SEARCH:
          begin
            tick_cnt_r <= tick ? 24'h000000 : tick_cnt_r + 24'h000001;
            if (tick)
            begin
              attempt_r <= 1'b1; // [RULE2] [RULE3]
              attempts_r <= attempts_r + 6'h01;
              if (i_far_end_present)
                state_r <= DET_FOUND;
              else if (last_attempt)
                state_r <= DET_STOPPED; // [RULE2]
            end
          end
          DET_HIZ, DET_FOUND, DET_STOPPED:
          begin
            tick_cnt_r <= 24'h000000;
          end
        endcase
      end
    end
  end

  // termination: fixed code, or auto after success only
  assign o_term_50 = (mode_last_r == DETECT_FIXED_50) ||
                     (state_r == DET_FOUND); // [RULE4] [RULE5]
  assign o_attempt = attempt_r;

endmodule : rx_detect_seq

// *** tb/far_end_rx_model.sv ***
// far-end receiver model answering the lane detect probe
// assumes probes arrive as one-cycle pulses on i_clock
`timescale 1ns/100ps
module far_end_rx_model
(
  input wire logic i_clock,
  input wire logic i_clear,
  input wire logic i_attempt,
  input wire logic [7:0] i_need,
  output logic [7:0] o_count,
  output logic o_present
);
  // counts probes; need of zero means no receiver at all
  always_ff @(posedge i_clock)
    if (i_clear)
      o_count <= 8'h00;
    else if (i_attempt)
      o_count <= o_count + 8'h01;
  assign o_present = i_need != 8'h00 && o_count >= i_need;
endmodule : far_end_rx_model

// *** tb/lane_cond_assertions.sv ***
// assertions for the lane register slice
// assumes it is bound into lane_conditioning_ctrl_regs
`timescale 1ns/100ps
module lane_cond_checker
(
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_RD,
  input wire logic [7:0] O_RD_DATA,
  input wire logic O_RD_HIT,
  input wire logic I_DETECT_OVERRIDE,
  input wire logic O_DETECT_ATTEMPT,
  input wire logic O_LANE_ZERO_INPUT_TERM,
  input wire logic [7:0] O_EQUALIZER_SETTING,
  input wire logic O_SHORT_PROT_EN,
  input wire logic [2:0] O_OUTPUT_SWING,
  input wire logic [2:0] O_DEEMPHASIS_LEVEL
);
  default clocking @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST);
  // strobe decodes and write fields
  wire wr_det = I_REG_WR && I_REG_ADDR == 8'h2b && I_DETECT_OVERRIDE;
  wire wr_sw = I_REG_WR && I_REG_ADDR == 8'h2d;
  wire wr_dm = I_REG_WR && I_REG_ADDR == 8'h2e;
  wire hit = I_REG_ADDR >= 8'h2b && I_REG_ADDR <= 8'h33;
  wire term = O_LANE_ZERO_INPUT_TERM;
  wire [3:0] sw = {I_REG_WDATA[7], I_REG_WDATA[2:0]};
  wire [2:0] dm = I_REG_WDATA[2:0];
  logic [1:0] code_r;
  // shadow of the detect code under register control
  always_ff @(posedge I_CLOCK)
    if (I_SYS_RST)
      code_r <= 2'b00;
    else if (wr_det)
      code_r <= I_REG_WDATA[3:2];
  chk_eq_write: assert property (
    I_REG_WR && I_REG_ADDR == 8'h2c |=>
    O_EQUALIZER_SETTING == $past(I_REG_WDATA))
    else $error("equalizer missed a write");
  chk_swing_write: assert property (
    wr_sw |=> {O_SHORT_PROT_EN, O_OUTPUT_SWING} == $past(sw))
    else $error("swing or protection missed a write");
  chk_deemph_write: assert property (
    wr_dm |=> O_DEEMPHASIS_LEVEL == $past(dm))
    else $error("deemphasis missed a write");
  chk_fixed_term: assert property (
    wr_det && I_REG_WDATA[3:2] == 2'b11 |-> ##[1:3] term)
    else $error("fixed code gave no termination");
  chk_hiz_input: assert property (
    wr_det && I_REG_WDATA[3:2] == 2'b00 |-> ##[1:3] !term)
    else $error("off code left termination on");
  chk_term_probe: assert property (
    $rose(term) && I_DETECT_OVERRIDE && code_r inside {2'b01, 2'b10}
    |-> O_DETECT_ATTEMPT || $past(O_DETECT_ATTEMPT))
    else $error("termination without a probe");
  chk_read_hit: assert property (
    I_REG_RD |=> O_RD_HIT == $past(hit))
    else $error("read hit flag wrong");
  chk_status_read: assert property (
    I_REG_RD && I_REG_ADDR == 8'h2e |=>
    O_RD_DATA[7] == term || O_RD_DATA[7] == $past(term))
    else $error("status bit disagrees with termination");
  cover property (O_DETECT_ATTEMPT);
  cover property ($rose(term));
  cover property (I_REG_RD && !hit);
endmodule : lane_cond_checker

bind lane_conditioning_ctrl_regs lane_cond_checker u_chk (.I_CLOCK,
  .I_SYS_RST, .I_REG_ADDR, .I_REG_WR, .I_REG_WDATA, .I_REG_RD, .O_RD_DATA,
  .O_RD_HIT, .I_DETECT_OVERRIDE, .O_DETECT_ATTEMPT, .O_LANE_ZERO_INPUT_TERM,
  .O_EQUALIZER_SETTING, .O_SHORT_PROT_EN, .O_OUTPUT_SWING,
  .O_DEEMPHASIS_LEVEL);

// *** tb/tb_lane_conditioning_ctrl_regs.sv ***
// self-checking bench for the lane register slice
// assumes 200 MHz clock and a detect interval of 4 cycles
`timescale 1ns/100ps
module tb_lane_conditioning_ctrl_regs;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, need = 8'h00;
  logic det_ovr = 1'b1, mode_ovr = 1'b0, mode_pin = 1'b0, clr = 1'b1;
  logic [1:0] det_pin = 2'b00;
  logic far, hit, attempt, term, sc, gen12;
  logic [7:0] rdata, cnt, eq;
  logic [2:0] swing, lane_a0_deemph_ctrl;
  int fails = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  lane_conditioning_ctrl_regs #(.DETECT_INTERVAL(4)) uut (.I_CLOCK(clk),
    .I_SYS_RST(rst), .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata),
    .I_REG_RD(rd), .O_RD_DATA(rdata), .O_RD_HIT(hit),
    .I_DETECT_OVERRIDE(det_ovr), .I_DETECT_PIN(det_pin),
    .I_MODE_OVERRIDE(mode_ovr), .I_MODE_PIN(mode_pin),
    .I_FAR_END_PRESENT(far), .O_DETECT_ATTEMPT(attempt),
    .O_LANE_ZERO_INPUT_TERM(term), .O_EQUALIZER_SETTING(eq),
    .O_SHORT_PROT_EN(sc), .O_PROTO_GEN12(gen12), .O_OUTPUT_SWING(swing),
    .O_DEEMPHASIS_LEVEL(lane_a0_deemph_ctrl));
  far_end_rx_model far_rx (.i_clock(clk), .i_clear(clr), .i_attempt(attempt),
    .i_need(need), .o_count(cnt), .o_present(far));
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one write: strobe held across exactly one rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] d, input h);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, d);
    chk({7'h00, hit}, {7'h00, h});
  endtask : rd_reg
  task automatic wait_term(input logic e);
    int n;
    n = 0;
    while (term !== e && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, term}, {7'h00, e});
    if (term !== e)
      stop_test();
  endtask : wait_term
  task automatic t_defaults();
    logic [7:0] dflt [9];
    dflt = '{8'h00, 8'h2f, 8'had, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2f};
    for (int i = 0; i < 9; i++)
      rd_reg(8'h2b + 8'(i), dflt[i], 1'b1);
    rd_reg(8'h2a, 8'h00, 1'b0);
    chk(eq, 8'h2f);
    chk({4'h0, sc, swing}, 8'h0d);
    chk({5'h00, lane_a0_deemph_ctrl}, 8'h02);
  endtask : t_defaults
  task automatic t_detect();
    wr_reg(8'h2b, 8'h0c);
    wait_term(1'b1);
    wr_reg(8'h2b, 8'h00);
    wait_term(1'b0);
    need = 8'h03;
    wr_reg(8'h2b, 8'h08);
    wait_term(1'b1);
    rd_reg(8'h2e, 8'h82, 1'b1);
    need = 8'h00;
    wr_reg(8'h2b, 8'h04);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (400) @(negedge clk);
    chk(cnt, 8'h32);
    chk({7'h00, term}, 8'h00);
  endtask : t_detect
  task automatic t_pin();
    det_ovr = 1'b0;
    det_pin = 2'b11;
    wait_term(1'b1);
    det_pin = 2'b00;
    wait_term(1'b0);
    det_ovr = 1'b1;
    wr_reg(8'h2b, 8'h00);
  endtask : t_pin
  task automatic t_swing();
    logic [2:0] c;
    mode_pin = 1'b1;
    wr_reg(8'h2d, 8'h28);
    repeat (3) @(negedge clk);
    chk({7'h00, gen12}, 8'h01);
    mode_ovr = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      wr_reg(8'h2d, {c[0], c[1], 3'b101, c});
      @(negedge clk);
      chk({3'h0, sc, gen12, swing}, {3'h0, c[0], c[1], c});
    end
  endtask : t_swing
  task automatic t_fields();
    logic [2:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      wr_reg(8'h2e, {5'h10, c});
      chk({5'h00, lane_a0_deemph_ctrl}, {5'h00, c});
      rd_reg(8'h2e, {5'h00, c}, 1'b1);
    end
    wr_reg(8'h2c, 8'hff);
    chk(eq, 8'hff);
    wr_reg(8'h33, 8'ha5);
    rd_reg(8'h33, 8'ha5, 1'b1);
    wr_reg(8'h34, 8'h5a);
    rd_reg(8'h34, 8'h00, 1'b0);
  endtask : t_fields
  // mid-run reset must bring equalizer, swing, protocol, termination, read data and detect code back to defaults
  task automatic t_reset();
    wr_reg(8'h2c, 8'h11);
    wr_reg(8'h2b, 8'h0c);
    rd_reg(8'h2c, 8'h11, 1'b1);
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk(eq, 8'h2f);
    chk({4'h0, sc, swing}, 8'h0d);
    chk({7'h00, gen12}, 8'h00);
    chk({7'h00, term}, 8'h00);
    chk(rdata, 8'h00);
    rd_reg(8'h2b, 8'h00, 1'b1);
  endtask : t_reset
  // main sequence: reset, then each scenario in turn
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    clr = 1'b0;
    t_defaults();
    t_detect();
    t_pin();
    t_swing();
    t_fields();
    t_reset();
    stop_test();
  end
endmodule : tb_lane_conditioning_ctrl_regs
